// *** rtl/tsr_regbank.sv ***
// register bank of the touch-screen digitizer controller
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
// Contract
// - word 0x01 conversion control, rw, resets 0x0000
// - bit 15 picks pen-down or limit alert
// - bits 14:12 pick single-conversion input channel
// - codes 111..011 map position, pressure, aux inputs
// - word 0x02 power and filter, resets 0x4040
// - word 0x03 limit status, enables, sequence channels
// - words 0x04..0x07 hold aux and temperature limits
// - results read-only at 0x08..0x0d, reset zero
// - word 0x0e returns a fixed identity word
// - 010 battery, 001 temperature; mode codes 11:10
// - mode clears when sequence ends with timer zero
module tsr_regbank #(
	parameter logic [15:0] REV_ID = tsr_pkg::REV_ID_DEFAULT // arbitrary value
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	// word access from the serial host front end
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic [3:0] host_addr_i,
	input wire logic [15:0] host_wdata_i,
	output logic [15:0] host_rdata_o,
	output logic host_rvalid_o,
	// results from the converter sequencer
	input wire logic res_valid_i,
	input wire logic [2:0] res_chan_i,
	input wire logic [15:0] res_data_i,
	input wire logic seq_done_i,
	// touch detect pin, asynchronous
	input wire logic pen_touch_i,
	// decoded controls toward the converter
	output logic [2:0] manual_channel_sel_o,
	output logic [1:0] conv_mode_o,
	output logic [1:0] acq_time_o,
	output logic [7:0] interval_timer_field_o,
	output logic [15:0] power_filter_o,
	output logic [7:0] seq_channels_o,
	// shared interrupt pin, active low
	output logic pen_down_irq_n_o
);

	//////////////////////////////////////////////////////////////////////////
	// storage
	// the identity word keeps a slot in the array but is never loaded;
	// reads take the parameter, so no write can ever disturb it
	logic [15:0] regs_ff [tsr_pkg::NUM_REGS]; // words 0x0 .. 0xe
	logic [15:0] nxt_regs [tsr_pkg::NUM_REGS];
	logic [15:0] rdata_ff; // read data
	logic [15:0] nxt_rdata;
	logic rvalid_ff; // read answer strobe
	logic nxt_rvalid;
	logic irq_n_ff; // interrupt pin level
	logic nxt_irq_n;
	logic [2:0] pen_sync_ff; // three-stage pin synchroniser
	logic pen_ff; // filtered touch level
	logic nxt_pen;

	// result routing
	tsr_res_if res ();
	logic lim_above; // result over its upper limit
	logic lim_below; // result under its lower limit
	logic [15:0] lim_upper; // chosen upper limit
	logic [15:0] lim_lower; // chosen lower limit

	//////////////////////////////////////////////////////////////////////////
	// helper functions

	// reset value per word
	// only the power word has a non-zero default
	function automatic logic [15:0] rst_value(input int unsigned idx);
		logic [15:0] val;
		val = tsr_pkg::RST_ZERO;
		if (idx == int'(tsr_pkg::ADDR_PWR_FILT)) begin
			val = tsr_pkg::RST_PWR_FILT;
		end
		return val;
	endfunction

	// host may store into this word
	// words 0x0..0x7 only; results and identity are read-only
	function automatic logic host_writable(input logic [3:0] addr);
		return addr <= tsr_pkg::ADDR_LAST_RW;
	endfunction

	// word exists in the map
	// 0xf is the only hole in the map
	function automatic logic mapped(input logic [3:0] addr);
		return addr <= tsr_pkg::ADDR_REV_ID;
	endfunction

	// any limit status whose enable bit is also set
	function automatic logic alert_of(input logic [15:0] word);
		logic found;
		found = 1'b0;
		for (int unsigned s = tsr_pkg::ST_AUX_HI; s <= tsr_pkg::ST_TEMP_LO; s++) begin
			found = found | (word[s] & word[s + tsr_pkg::EN_SHIFT]);
		end
		return found;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// channel decode and limit compare
	// aux and battery share one word and one pair of limits; the decoder
	// flags the class so the comparator is fed the matching pair
	assign res.valid = res_valid_i;
	assign res.chan = res_chan_i;

	// pure decode of the result channel code
	tsr_chan_decode u_decode (
		.res (res)
	);

	// thresholds picked by result class
	// position and pressure results pass the compare too, but no status takes it
	always_comb begin
		if (res.is_temp) begin
			lim_upper = regs_ff[tsr_pkg::ADDR_TEMP_HI];
			lim_lower = regs_ff[tsr_pkg::ADDR_TEMP_LO];
		end else begin
			// aux, battery and every other code
			lim_upper = regs_ff[tsr_pkg::ADDR_AUX_HI];
			lim_lower = regs_ff[tsr_pkg::ADDR_AUX_LO];
		end
	end

	// one comparator serves both classes; results never arrive two at once
	tsr_limit_cmp u_limit (
		.value_i (res_data_i),
		.upper_i (lim_upper),
		.lower_i (lim_lower),
		.above_o (lim_above),
		.below_o (lim_below)
	);

	//////////////////////////////////////////////////////////////////////////
	// register next values
	// order matters: sequencer clear, then host write, then hardware set,
	// so a status event in the clearing cycle survives
	always_comb begin
		logic [15:0] lim_word;
		lim_word = '0;
		for (int unsigned i = 0; i < tsr_pkg::NUM_REGS; i++) begin
			nxt_regs[i] = regs_ff[i];
		end
		// every word holds unless a branch below changes it
		// single or slave run ends with no interval: back to idle
		if (seq_done_i && regs_ff[tsr_pkg::ADDR_CONV_CTRL][tsr_pkg::TMR_HI:tsr_pkg::TMR_LO]
			== 8'h00) begin
			nxt_regs[tsr_pkg::ADDR_CONV_CTRL][tsr_pkg::MODE_HI:tsr_pkg::MODE_LO] =
				tsr_pkg::MODE_NONE;
		end
		// a host write to word 1 in the same cycle wins over the clear above,
		// so a fresh mode from the host is never lost
		// host write; read-only and unmapped words keep their value
		if (host_wr_i && host_writable(host_addr_i)) begin
			if (host_addr_i == tsr_pkg::ADDR_LIMIT_SEQ) begin
				// status bits: writing 1 clears, 0
				lim_word = (host_wdata_i & ~tsr_pkg::STATUS_MASK) |
					(regs_ff[tsr_pkg::ADDR_LIMIT_SEQ] & tsr_pkg::STATUS_MASK & ~host_wdata_i);
				nxt_regs[tsr_pkg::ADDR_LIMIT_SEQ] = lim_word;
			end else begin
				nxt_regs[host_addr_i] = host_wdata_i;
			end
		end
		// converter results land in read-only words
		// channel code 0 and an idle strobe both leave hit low: nothing stored
		if (res.hit) begin
			nxt_regs[res.idx] = res_data_i;
		end
		// out-of-limit results set sticky status
		// applied after the host write, so a set beats a clear in one cycle
		if (res.is_aux) begin
			nxt_regs[tsr_pkg::ADDR_LIMIT_SEQ][tsr_pkg::ST_AUX_HI] =
				nxt_regs[tsr_pkg::ADDR_LIMIT_SEQ][tsr_pkg::ST_AUX_HI] | lim_above;
			nxt_regs[tsr_pkg::ADDR_LIMIT_SEQ][tsr_pkg::ST_AUX_LO] =
				nxt_regs[tsr_pkg::ADDR_LIMIT_SEQ][tsr_pkg::ST_AUX_LO] | lim_below;
		end
		if (res.is_temp) begin
			nxt_regs[tsr_pkg::ADDR_LIMIT_SEQ][tsr_pkg::ST_TEMP_HI] =
				nxt_regs[tsr_pkg::ADDR_LIMIT_SEQ][tsr_pkg::ST_TEMP_HI] | lim_above;
			nxt_regs[tsr_pkg::ADDR_LIMIT_SEQ][tsr_pkg::ST_TEMP_LO] =
				nxt_regs[tsr_pkg::ADDR_LIMIT_SEQ][tsr_pkg::ST_TEMP_LO] | lim_below;
		end
		// identity word is never stored, it is a constant on read
		nxt_regs[tsr_pkg::ADDR_REV_ID] = tsr_pkg::RST_ZERO;
	end

	// register words, every one back to its default
	// the reset branch loads constants only; rst_value folds per index
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int unsigned i = 0; i < tsr_pkg::NUM_REGS; i++) begin
				regs_ff[i] <= rst_value(i);
			end
		end else begin
			for (int unsigned i = 0; i < tsr_pkg::NUM_REGS; i++) begin
				regs_ff[i] <= nxt_regs[i];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// host read path, one cycle latency
	// a read and a write in one cycle: the read returns the word as it was
	// read data holds between reads, so a slow host may sample it late
	always_comb begin
		nxt_rvalid = host_rd_i;
		nxt_rdata = rdata_ff;
		if (host_rd_i) begin
			// identity first: its array slot stays zero
			if (host_addr_i == tsr_pkg::ADDR_REV_ID) begin
				nxt_rdata = REV_ID;
			end else if (mapped(host_addr_i)) begin
				nxt_rdata = regs_ff[host_addr_i];
			end else begin
				nxt_rdata = tsr_pkg::RST_ZERO; // unmapped reads as zero
			end
		end
	end

	// read answer registers
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_ff <= tsr_pkg::RST_ZERO;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// touch pin synchroniser; level moves only once stages two and three agree
	// stage one may go metastable and is read by nothing but stage two; a
	// pulse that lasts only one clock never reaches the pin logic
	always_comb begin
		nxt_pen = pen_ff;
		if (pen_sync_ff[1] == pen_sync_ff[2]) begin
			nxt_pen = pen_sync_ff[2];
		end
	end

	// stage shift and filtered level
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pen_sync_ff <= 3'h0;
			pen_ff <= 1'b0;
		end else begin
			pen_sync_ff <= {pen_sync_ff[1:0], pen_touch_i};
			pen_ff <= nxt_pen;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// interrupt pin function
	// pen mode follows the touch level; alert mode ors masked limit status
	// the pin is one flop behind the status, so a host clear shows a cycle later
	always_comb begin
		logic [15:0] lim;
		logic alert;
		lim = regs_ff[tsr_pkg::ADDR_LIMIT_SEQ];
		alert = alert_of(lim); // status gated by enable
		if (regs_ff[tsr_pkg::ADDR_CONV_CTRL][tsr_pkg::PEN_OFF_BIT]) begin
			nxt_irq_n = ~alert;
		end else begin
			nxt_irq_n = ~pen_ff;
		end
	end

	// reset parks the pin inactive so no false alert follows reset
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_n_ff <= 1'b1;
		end else begin
			irq_n_ff <= nxt_irq_n;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs, all taken from flip-flops
	// control fields go out as levels with no handshake; a host write
	// reaches the converter on the very next clock
	assign host_rdata_o = rdata_ff;
	assign host_rvalid_o = rvalid_ff;
	assign pen_down_irq_n_o = irq_n_ff;
	// channel field only matters in single mode; the converter gates it
	assign manual_channel_sel_o =
		regs_ff[tsr_pkg::ADDR_CONV_CTRL][tsr_pkg::CHAN_HI:tsr_pkg::CHAN_LO];
	assign conv_mode_o = regs_ff[tsr_pkg::ADDR_CONV_CTRL][tsr_pkg::MODE_HI:tsr_pkg::MODE_LO];
	assign acq_time_o = regs_ff[tsr_pkg::ADDR_CONV_CTRL][tsr_pkg::ACQ_HI:tsr_pkg::ACQ_LO];
	assign interval_timer_field_o =
		regs_ff[tsr_pkg::ADDR_CONV_CTRL][tsr_pkg::TMR_HI:tsr_pkg::TMR_LO];
	assign power_filter_o = regs_ff[tsr_pkg::ADDR_PWR_FILT];
	assign seq_channels_o =
		regs_ff[tsr_pkg::ADDR_LIMIT_SEQ][tsr_pkg::SEQ_HI:tsr_pkg::SEQ_LO];

endmodule

// *** include/tsr_pkg.sv ***
// constants and types shared by the touch-screen register bank
package tsr_pkg;

	////////////////////////////////////////////////////////////////////////
	// widths
	localparam int unsigned DATA_W = 16; // every register is one 16-bit word
	localparam int unsigned ADDR_W = 4; // word address from the serial host
	localparam int unsigned NUM_REGS = 15; // words 0x0 .. 0xe

	////////////////////////////////////////////////////////////////////////
	// register word addresses
	localparam logic [3:0] ADDR_SPARE = 4'h0;
	localparam logic [3:0] ADDR_CONV_CTRL = 4'h1;
	localparam logic [3:0] ADDR_PWR_FILT = 4'h2;
	localparam logic [3:0] ADDR_LIMIT_SEQ = 4'h3;
	localparam logic [3:0] ADDR_AUX_HI = 4'h4;
	localparam logic [3:0] ADDR_AUX_LO = 4'h5;
	localparam logic [3:0] ADDR_TEMP_HI = 4'h6;
	localparam logic [3:0] ADDR_TEMP_LO = 4'h7;
	localparam logic [3:0] ADDR_Y_POS = 4'h8;
	localparam logic [3:0] ADDR_X_POS = 4'h9;
	localparam logic [3:0] ADDR_Z1 = 4'ha;
	localparam logic [3:0] ADDR_Z2 = 4'hb;
	localparam logic [3:0] ADDR_AUX_RES = 4'hc;
	localparam logic [3:0] ADDR_TEMP_RES = 4'hd;
	localparam logic [3:0] ADDR_REV_ID = 4'he;
	localparam logic [3:0] ADDR_LAST_RW = 4'h7; // highest writable word

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_PWR_FILT = 16'h4040;
	localparam logic [15:0] REV_ID_DEFAULT = 16'h0a5c; // arbitrary value

	////////////////////////////////////////////////////////////////////////
	// conversion control field positions
	localparam int unsigned PEN_OFF_BIT = 15;
	localparam int unsigned CHAN_HI = 14;
	localparam int unsigned CHAN_LO = 12;
	localparam int unsigned MODE_HI = 11;
	localparam int unsigned MODE_LO = 10;
	localparam int unsigned ACQ_HI = 9;
	localparam int unsigned ACQ_LO = 8;
	localparam int unsigned TMR_HI = 7;
	localparam int unsigned TMR_LO = 0;

	////////////////////////////////////////////////////////////////////////
	// limit status / enable field positions in the limit word
	localparam int unsigned ST_AUX_HI = 0;
	localparam int unsigned ST_AUX_LO = 1;
	localparam int unsigned ST_TEMP_HI = 2;
	localparam int unsigned ST_TEMP_LO = 3;
	localparam int unsigned EN_SHIFT = 4; // enable sits four above its status
	localparam logic [15:0] STATUS_MASK = 16'h000f;
	localparam int unsigned SEQ_HI = 15;
	localparam int unsigned SEQ_LO = 8;

	////////////////////////////////////////////////////////////////////////
	// channel codes of the manual channel field
	localparam logic [2:0] CH_Y_POS = 3'h7;
	localparam logic [2:0] CH_X_POS = 3'h6;
	localparam logic [2:0] CH_Z1 = 3'h5;
	localparam logic [2:0] CH_Z2 = 3'h4;
	localparam logic [2:0] CH_AUX = 3'h3;
	localparam logic [2:0] CH_BATT = 3'h2;
	localparam logic [2:0] CH_TEMP = 3'h1;
	localparam logic [2:0] CH_NONE = 3'h0;

	// conversion mode encoding, in code order 00..11
	typedef enum logic [1:0] {
		MODE_NONE,
		MODE_SINGLE,
		MODE_SLAVE_SEQ,
		MODE_MASTER_SEQ
	} tsr_mode_t;

endpackage

// *** include/tsr_res_if.sv ***
// result routing signals between the bank and its channel decoder
`timescale 1ns/100ps
interface tsr_res_if;
	logic valid; // result strobe
	logic [2:0] chan; // channel code of the result
	logic hit; // code maps to a result word
	logic [3:0] idx; // result word address
	logic is_aux; // aux or battery result
	logic is_temp; // temperature result
	modport decoder(input valid, input chan, output hit, output idx, output is_aux,
		output is_temp);
	modport bank(output valid, output chan, input hit, input idx, input is_aux,
		input is_temp);
endinterface

// *** rtl/tsr_chan_decode.sv ***
// maps a channel code to its result word and limit class
`timescale 1ns/100ps
module tsr_chan_decode (
	tsr_res_if.decoder res
);

	////////////////////////////////////////////////////////////////////////
	// pure decode, no state
	always_comb begin
		res.hit = res.valid;
		res.idx = tsr_pkg::ADDR_SPARE;
		res.is_aux = 1'b0;
		res.is_temp = 1'b0;
		unique case (res.chan)
			tsr_pkg::CH_Y_POS: res.idx = tsr_pkg::ADDR_Y_POS;
			tsr_pkg::CH_X_POS: res.idx = tsr_pkg::ADDR_X_POS;
			tsr_pkg::CH_Z1: res.idx = tsr_pkg::ADDR_Z1;
			tsr_pkg::CH_Z2: res.idx = tsr_pkg::ADDR_Z2;
			tsr_pkg::CH_AUX, tsr_pkg::CH_BATT: begin
				// aux and battery share one result word
				res.idx = tsr_pkg::ADDR_AUX_RES;
				res.is_aux = res.valid;
			end
			tsr_pkg::CH_TEMP: begin
				res.idx = tsr_pkg::ADDR_TEMP_RES;
				res.is_temp = res.valid;
			end
			tsr_pkg::CH_NONE: res.hit = 1'b0; // no channel, nothing stored
		endcase
	end

endmodule

// *** rtl/tsr_limit_cmp.sv ***
// compares one result against an upper and a lower threshold
`timescale 1ns/100ps
module tsr_limit_cmp (
	input wire logic [15:0] value_i,
	input wire logic [15:0] upper_i,
	input wire logic [15:0] lower_i,
	output logic above_o,
	output logic below_o
);

	////////////////////////////////////////////////////////////////////////
	// strict compare: a value equal to a limit is still in range
	always_comb begin
		above_o = value_i > upper_i;
		below_o = value_i < lower_i;
	end

endmodule

// *** dv/tsr_regbank_chk.sv ***
// port assertions of the register bank
`timescale 1ns/100ps
module tsr_regbank_chk #(
	parameter logic [15:0] REV_ID = 16'h0000 // arbitrary value
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic [3:0] host_addr_i,
	input wire logic [15:0] host_wdata_i,
	input wire logic [15:0] host_rdata_o,
	input wire logic host_rvalid_o,
	input wire logic seq_done_i,
	input wire logic [2:0] manual_channel_sel_o,
	input wire logic [1:0] conv_mode_o,
	input wire logic [1:0] acq_time_o,
	input wire logic [7:0] interval_timer_field_o,
	input wire logic [15:0] power_filter_o,
	input wire logic [7:0] seq_channels_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);
	logic wr_conv; // host write aimed at the conversion word
	assign wr_conv = host_wr_i && (host_addr_i == 4'h1);
	////////////////////////////////////////////////////////////////////////
	// read port timing and fixed words
	property p_rvalid;
		host_rd_i ##1 !host_rd_i |-> host_rvalid_o ##1 !host_rvalid_o;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read answer pulse wrong");
	property p_rev;
		host_rd_i && host_addr_i == 4'he |=> host_rdata_o == REV_ID;
	endproperty
	a_rev: assert property (p_rev) else $error("identity word wrong");
	property p_unmapped;
		host_rd_i && host_addr_i == 4'hf |=> host_rdata_o == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	////////////////////////////////////////////////////////////////////////
	// writes reach the control outputs one cycle later
	property p_conv_wr;
		wr_conv |=> {manual_channel_sel_o, conv_mode_o, acq_time_o, interval_timer_field_o}
			== $past(host_wdata_i[14:0]);
	endproperty
	a_conv_wr: assert property (p_conv_wr) else $error("conversion word not taken");
	property p_pwr_wr;
		host_wr_i && host_addr_i == 4'h2 |=> power_filter_o == $past(host_wdata_i);
	endproperty
	a_pwr_wr: assert property (p_pwr_wr) else $error("power word not taken");
	property p_seq_wr;
		host_wr_i && host_addr_i == 4'h3 |=> seq_channels_o == $past(host_wdata_i[15:8]);
	endproperty
	a_seq_wr: assert property (p_seq_wr) else $error("sequence channels not taken");
	property p_mode_clr;
		seq_done_i && interval_timer_field_o == 8'h00 && !wr_conv |=> conv_mode_o == 2'h0;
	endproperty
	a_mode_clr: assert property (p_mode_clr) else $error("mode not cleared");
	property p_conv_hold;
		!wr_conv && !seq_done_i |=> $stable({manual_channel_sel_o, conv_mode_o, acq_time_o});
	endproperty
	a_conv_hold: assert property (p_conv_hold) else $error("conversion word moved");
	property p_pwr_hold;
		!(host_wr_i && host_addr_i == 4'h2) |=> $stable(power_filter_o);
	endproperty
	a_pwr_hold: assert property (p_pwr_hold) else $error("power word moved");
endmodule

// *** dv/tsr_host_model.sv ***
// host side model issuing word reads and writes
`timescale 1ns/100ps
module tsr_host_model (
	input wire logic mclk_i,
	input wire logic [15:0] host_rdata_i,
	input wire logic host_rvalid_i,
	output logic host_wr_o,
	output logic host_rd_o,
	output logic [3:0] host_addr_o,
	output logic [15:0] host_wdata_o
);
	int to_cnt = 0; // reads that never answered
	// idle bus at time zero
	initial begin
		host_wr_o = 1'b0;
		host_rd_o = 1'b0;
		host_addr_o = 4'h0;
		host_wdata_o = 16'h0000;
	end
	// one word write, taken at the single rising edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(negedge mclk_i);
		host_wr_o = 1'b1;
		host_addr_o = a;
		host_wdata_o = d;
		@(negedge mclk_i);
		host_wr_o = 1'b0;
		host_wdata_o = ~d; // released data shows no stale word
	endtask
	// one word read, bounded wait on the answer pulse
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		int i;
		@(negedge mclk_i);
		host_rd_o = 1'b1;
		host_addr_o = a;
		@(negedge mclk_i);
		host_rd_o = 1'b0;
		for (i = 0; i < 4 && host_rvalid_i !== 1'b1; i++) @(negedge mclk_i);
		if (host_rvalid_i !== 1'b1) to_cnt++;
		d = host_rdata_i;
	endtask
endmodule

// *** dv/touch_adc_register_map_tb.sv ***
// self-checking bench of the register bank
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module touch_adc_register_map_tb;
	localparam logic [15:0] REV = 16'h1234; // arbitrary value
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic host_wr_i, host_rd_i, host_rvalid_o, pen_down_irq_n_o;
	logic [3:0] host_addr_i;
	logic [15:0] host_wdata_i, host_rdata_o, power_filter_o;
	logic res_valid_i = 1'b0;
	logic seq_done_i = 1'b0;
	logic pen_touch_i = 1'b0;
	logic [2:0] res_chan_i = 3'h0;
	logic [15:0] res_data_i = 16'h0000;
	logic [2:0] manual_channel_sel_o;
	logic [1:0] conv_mode_o, acq_time_o;
	logic [7:0] interval_timer_field_o, seq_channels_o;
	int err_total = 0;
	int n_tests = 0;
	initial begin
		forever #10 mclk_i = ~mclk_i;
	end
	tsr_regbank #(.REV_ID(REV)) u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
		.host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_addr_i(host_addr_i),
		.host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
		.host_rvalid_o(host_rvalid_o), .res_valid_i(res_valid_i), .res_chan_i(res_chan_i),
		.res_data_i(res_data_i), .seq_done_i(seq_done_i), .pen_touch_i(pen_touch_i),
		.manual_channel_sel_o(manual_channel_sel_o), .conv_mode_o(conv_mode_o),
		.acq_time_o(acq_time_o), .interval_timer_field_o(interval_timer_field_o),
		.power_filter_o(power_filter_o), .seq_channels_o(seq_channels_o),
		.pen_down_irq_n_o(pen_down_irq_n_o));
	tsr_host_model u_host (.mclk_i(mclk_i), .host_rdata_i(host_rdata_o),
		.host_rvalid_i(host_rvalid_o), .host_wr_o(host_wr_i), .host_rd_o(host_rd_i),
		.host_addr_o(host_addr_i), .host_wdata_o(host_wdata_i));
	////////////////////////////////////////////////////////////////////////
	// helpers
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// read a word and return it, a dead answer ends the run
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		u_host.rd(a, d);
		if (u_host.to_cnt != 0) begin
			err_total++;
			final_report();
		end
	endtask
	// write pattern keeps the status nibble clear
	function automatic logic [15:0] pat(input logic [3:0] a);
		return {4'ha, a, 8'h50};
	endfunction
	// one converter result pulse
	task automatic res(input logic [2:0] c, input logic [15:0] d);
		@(negedge mclk_i);
		res_valid_i = 1'b1;
		res_chan_i = c;
		res_data_i = d;
		@(negedge mclk_i);
		res_valid_i = 1'b0;
	endtask
	// bounded wait for the interrupt pin level
	task automatic wait_irq(input logic v);
		int i;
		for (i = 0; i < 8 && pen_down_irq_n_o !== v; i++) @(negedge mclk_i);
		`CHK(pen_down_irq_n_o, v)
		if (pen_down_irq_n_o !== v) final_report();
	endtask
	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_defaults();
		logic [15:0] d;
		for (int a = 0; a < 16; a++) begin
			rd(a[3:0], d);
			`CHK(d, a == 2 ? 16'h4040 : a == 14 ? REV : 16'h0000)
		end
		`CHK(power_filter_o, 16'h4040)
	endtask
	task automatic t_rw();
		logic [15:0] d;
		for (int a = 0; a < 8; a++) u_host.wr(a[3:0], pat(a[3:0]));
		for (int a = 0; a < 8; a++) begin
			rd(a[3:0], d);
			`CHK(d, pat(a[3:0]))
		end
		`CHK({manual_channel_sel_o, conv_mode_o, acq_time_o}, 7'h21)
		`CHK(interval_timer_field_o, 8'h50)
		`CHK(seq_channels_o, 8'ha3)
	endtask
	// read-only and unmapped words ignore writes
	task automatic t_ro();
		logic [15:0] d;
		for (int a = 8; a < 16; a++) u_host.wr(a[3:0], 16'hffff);
		for (int a = 8; a < 16; a++) begin
			rd(a[3:0], d);
			`CHK(d, a == 14 ? REV : 16'h0000)
		end
	endtask
	// every non-zero channel code lands in its result word; code 0 stores nothing
	task automatic t_chan();
		logic [15:0] d;
		logic [3:0] w[8] = '{4'h0, 4'hd, 4'hc, 4'hc, 4'hb, 4'ha, 4'h9, 4'h8};
		u_host.wr(4'h4, 16'hffff);
		u_host.wr(4'h5, 16'h0000);
		u_host.wr(4'h6, 16'hffff);
		u_host.wr(4'h7, 16'h0000);
		for (int c = 7; c > 0; c--) begin
			res(c[2:0], 16'h0100 + 16'(c));
			rd(w[c], d);
			`CHK(d, 16'h0100 + 16'(c))
		end
		res(3'h0, 16'hbeef);
		rd(4'h0, d);
		`CHK(d, pat(4'h0))
	endtask
	// mode codes, sequence end clears only with timer zero
	task automatic t_mode();
		for (int m = 0; m < 4; m++) begin
			u_host.wr(4'h1, {4'h0, m[1:0], 10'h001});
			`CHK(conv_mode_o, m[1:0])
		end
		u_host.wr(4'h1, 16'h0401);
		@(negedge mclk_i) seq_done_i = 1'b1;
		@(negedge mclk_i) seq_done_i = 1'b0;
		`CHK(conv_mode_o, 2'h1)
		u_host.wr(4'h1, 16'h0400);
		@(negedge mclk_i) seq_done_i = 1'b1;
		@(negedge mclk_i) seq_done_i = 1'b0;
		`CHK(conv_mode_o, 2'h0)
	endtask
	// limit alert versus pen-down on the shared pin
	task automatic t_irq();
		logic [15:0] d;
		u_host.wr(4'h4, 16'h0100);
		u_host.wr(4'h1, 16'h8000);
		u_host.wr(4'h3, 16'h0010);
		res(3'h3, 16'h0200);
		wait_irq(1'b0);
		rd(4'h3, d);
		`CHK(d, 16'h0011)
		u_host.wr(4'h3, 16'h0011);
		wait_irq(1'b1);
		pen_touch_i = 1'b1;
		repeat (6) @(negedge mclk_i);
		`CHK(pen_down_irq_n_o, 1'b1)
		u_host.wr(4'h1, 16'h0000);
		wait_irq(1'b0);
		pen_touch_i = 1'b0;
		wait_irq(1'b1);
	endtask
	// a reset in mid-run brings every word back to its default
	task automatic t_rst();
		logic [15:0] d;
		u_host.wr(4'h1, 16'h0ff0);
		`CHK({conv_mode_o, interval_timer_field_o}, 10'h3f0)
		@(negedge mclk_i) arst_n_i = 1'b0;
		repeat (2) @(negedge mclk_i);
		arst_n_i = 1'b1;
		`CHK({conv_mode_o, interval_timer_field_o}, 10'h000)
		for (int a = 0; a < 14; a++) begin
			rd(a[3:0], d);
			`CHK(d, a == 2 ? 16'h4040 : 16'h0000)
		end
		`CHK(pen_down_irq_n_o, 1'b1)
	endtask
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (6) @(negedge mclk_i);
		arst_n_i = 1'b1;
		t_defaults();
		t_rw();
		t_ro();
		t_chan();
		t_mode();
		t_irq();
		t_rst();
		final_report();
	end
endmodule
bind tsr_regbank tsr_regbank_chk #(.REV_ID(REV_ID)) u_chk (.mclk_i(mclk_i),
	.arst_n_i(arst_n_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
	.host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
	.host_rvalid_o(host_rvalid_o), .seq_done_i(seq_done_i),
	.manual_channel_sel_o(manual_channel_sel_o), .conv_mode_o(conv_mode_o),
	.acq_time_o(acq_time_o), .interval_timer_field_o(interval_timer_field_o),
	.power_filter_o(power_filter_o), .seq_channels_o(seq_channels_o));
